/* common/dmacr_pkg.sv */
// Constants, register map and state encoding of the DMA channel request and addressing block.
// Assumes a 32-bit classic Wishbone register port and four channels.
package dmacr_pkg;

   localparam int          NUM_CH         = 4;

   // Register byte offsets.
   localparam logic [7:0]  OFS_CTL_BASE   = 8'h00;
   localparam logic [7:0]  OFS_OPER       = 8'h10;
   localparam logic [7:0]  OFS_STATUS     = 8'h14;
   localparam logic [7:0]  OFS_PTR_BASE   = 8'h20;

   // Channel control field positions; BIT_ON_DEMAND is a bit of the operation register.
   localparam int          BIT_ENABLE     = 0;
   localparam int          TS_LSB         = 4;
   localparam int          BIT_HOLD       = 7;
   localparam int          RS_LSB         = 8;
   localparam int          SM_LSB         = 12;
   localparam int          DM_LSB         = 14;
   localparam int          BIT_AL         = 16;
   localparam int          BIT_AM         = 17;
   localparam int          BIT_RL         = 18;
   localparam int          BIT_DS         = 19;
   localparam int          BIT_ON_DEMAND  = 15;

   // Writable bits; reserved bits and absent bits read as zero.
   localparam logic [31:0] CTL_MASK_LOW   = 32'hFF0F_FFF5;
   localparam logic [31:0] CTL_MASK_HIGH  = 32'hFF0A_FFF5;
   localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
   localparam logic [31:0] PTR_RESET      = 32'h0000_0000;

   // Request origin codes.
   localparam logic [3:0]  RS_EXT_DUAL    = 4'h0;
   localparam logic [3:0]  RS_EXT_M2D     = 4'h2;
   localparam logic [3:0]  RS_EXT_D2M     = 4'h3;
   localparam logic [3:0]  RS_AUTO_MM     = 4'h4;
   localparam logic [3:0]  RS_AUTO_MP     = 4'h5;
   localparam logic [3:0]  RS_AUTO_PM     = 4'h6;
   localparam logic [3:0]  RS_SP1_TX      = 4'h8;
   localparam logic [3:0]  RS_SP2_RX      = 4'hB;
   localparam logic [3:0]  RS_TMR_MM      = 4'hC;
   localparam logic [3:0]  RS_TMR_PM      = 4'hE;

   // Transfer size codes and pointer steps.
   localparam logic [2:0]  TS_QUAD        = 3'h0;
   localparam logic [2:0]  TS_BYTE        = 3'h1;
   localparam logic [2:0]  TS_WORD        = 3'h2;
   localparam logic [2:0]  TS_LONG        = 3'h3;
   localparam logic [2:0]  TS_BLOCK       = 3'h4;
   localparam logic [31:0] STEP_BYTE      = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD      = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG      = 32'h0000_0004;
   localparam logic [31:0] STEP_QUAD      = 32'h0000_0008;
   localparam logic [31:0] STEP_BLOCK     = 32'h0000_0020;
   localparam logic [1:0]  PSTEP_FIXED    = 2'h0;
   localparam logic [1:0]  PSTEP_INC      = 2'h1;
   localparam logic [1:0]  PSTEP_DEC      = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } dmacr_state_t;

endpackage

/* rtl/dmacr_channels.sv */
// Four-channel DMA request selection, handshake outputs and pointer stepping with Wishbone registers.
// Assumes on-chip request sources on core_clk and request pins asynchronous to it.
//
// Contract
// - Reserved control bits 23..20 read zero.
// - Sampling bit picks low level or falling edge.
// - Burst mode follows level or edge sampling.
// - Accept output polarity set by its bit.
// - Dual address ack in read or write.
// - Ack output polarity set by its bit.
// - Target step field fixed, increment, decrement.
// - Target step equals transfer size.
// - Memory to device single ignores target step.
// - Origin step field fixed, increment, decrement.
// - Origin step equals transfer size.
// - Device to memory single ignores origin step.
// - Code zero is external dual address.
// - Codes two, three are external single address.
// - Codes four to six are auto request.
// - Codes eight to eleven take serial requests.
// - Codes twelve to fourteen take timer capture.
// - Normal mode: external requests on channels 0,1.
// - On-demand mode: external requests on all channels.
// - Size field picks 64, 8, 16, 32 bit, block.
// - Auto request starts on enable; others wait.
`timescale 1ns/1ps
`default_nettype none
module dmacr_channels
   import dmacr_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Request sources.
   input  wire logic [3:0]  ext_xfer_request_pin_n,
   input  wire logic [3:0]  serial_req,
   input  wire logic        timer_capture_req,
   // External handshakes.
   output logic [3:0]       request_accepted_out,
   output logic [3:0]       transfer_ack_out,
   // Transfer phase toward the bus engine.
   output logic             xfer_valid_out,
   output logic             xfer_write_out,
   output logic [1:0]       xfer_chan_out,
   output logic [2:0]       xfer_size_out,
   output logic [31:0]      xfer_addr_out
);

   logic [31:0]  ctl_r [NUM_CH];
   logic [31:0]  ctl_nxt [NUM_CH];
   logic [31:0]  org_r [NUM_CH];
   logic [31:0]  org_nxt [NUM_CH];
   logic [31:0]  tgt_r [NUM_CH];
   logic [31:0]  tgt_nxt [NUM_CH];
   logic         ddt_r, ddt_nxt, ack_r, ack_nxt;
   logic [31:0]  dat_r, dat_nxt;
   logic [3:0]   pin_s1_r, pin_s2_r;
   logic [3:0]   det_req, chan_req, clr_pend, step_org, step_tgt;
   dmacr_state_t st_r, st_nxt;
   logic [1:0]   gnt_r, gnt_nxt;
   logic [3:0]   acc_r, acc_nxt;
   logic         val_r, val_nxt, wr_r, wr_nxt;
   logic [31:0]  addr_r, addr_nxt;
   logic [2:0]   size_r, size_nxt;
   logic         start, finish;
   logic [1:0]   start_ch;

   function automatic logic [31:0] step_ptr(input logic [31:0] ptr, input logic [1:0] mode, input logic [2:0] ts);
      logic [31:0] amt;
      amt = STEP_QUAD;
      case (ts)
         TS_BYTE:  amt = STEP_BYTE;
         TS_WORD:  amt = STEP_WORD;
         TS_LONG:  amt = STEP_LONG;
         TS_BLOCK: amt = STEP_BLOCK;
         default:  amt = STEP_QUAD;
      endcase
      case (mode)
         PSTEP_INC: step_ptr = ptr + amt;
         PSTEP_DEC: step_ptr = ptr - amt;
         default:   step_ptr = ptr;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         old[b*8 +: 8] = sel[b] ? val[b*8 +: 8] : old[b*8 +: 8];
      end
      merge = old;
   endfunction

   function automatic logic [3:0] rs_of(input logic [31:0] c);
      rs_of = c[RS_LSB +: 4];
   endfunction

   function automatic logic is_ext(input logic [3:0] rs);
      is_ext = (rs == RS_EXT_DUAL) || (rs == RS_EXT_M2D) || (rs == RS_EXT_D2M);
   endfunction

   // Settings that are invalid for a channel in the current mode act as their initial value; the register still reads back as written.
   function automatic logic ds_eff(input int ch, input logic on_demand_xfer, input logic [31:0] c);
      ds_eff = (on_demand_xfer || ch < 2) ? c[BIT_DS] : 1'b0;
   endfunction

   function automatic logic am_eff(input int ch, input logic on_demand_xfer, input logic [31:0] c);
      am_eff = (on_demand_xfer ? (ch > 0) : (ch < 2)) ? c[BIT_AM] : 1'b0;
   endfunction

   // Request pins cross into core_clk through two flip-flops.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_s1_r <= 4'hF;
         pin_s2_r <= 4'hF;
      end else begin
         pin_s1_r <= ext_xfer_request_pin_n;
         pin_s2_r <= pin_s1_r;
      end
   end

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      dmacr_req_detect u_det (
         .core_clk   (core_clk),
         .sys_rst    (sys_rst),
         .pin_sync_n (pin_s2_r[g]),
         .edge_mode  (ds_eff(g, ddt_r, ctl_r[g])),
         .clear_pend (clr_pend[g]),
         .req        (det_req[g])
      );
   end

   // Per-channel request qualification.
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         logic [3:0] rs;
         rs = rs_of(ctl_r[i]);
         chan_req[i] = 1'b0;
         if (rs == RS_EXT_DUAL || rs == RS_EXT_M2D || rs == RS_EXT_D2M) begin
            chan_req[i] = (ddt_r || i < 2) && det_req[i];
         end else if (rs >= RS_AUTO_MM && rs <= RS_AUTO_PM) begin
            chan_req[i] = 1'b1;
         end else if (rs >= RS_SP1_TX && rs <= RS_SP2_RX) begin
            chan_req[i] = serial_req[rs[1:0]];
         end else if (rs >= RS_TMR_MM && rs <= RS_TMR_PM) begin
            chan_req[i] = timer_capture_req;
         end
         chan_req[i] = chan_req[i] && ctl_r[i][BIT_ENABLE];
      end
   end

   // Transfer sequencer: one read and one write phase, or a single phase in single address mode.
   always_comb begin
      logic [31:0] c;
      logic [3:0]  rs;
      st_nxt   = st_r;
      gnt_nxt  = gnt_r;
      acc_nxt  = 4'h0;
      val_nxt  = 1'b0;
      wr_nxt   = 1'b0;
      addr_nxt = addr_r;
      size_nxt = size_r;
      start    = 1'b0;
      finish   = 1'b0;
      start_ch = 2'd0;
      step_org = 4'h0;
      step_tgt = 4'h0;
      c        = ctl_r[gnt_r];
      rs       = rs_of(c);
      for (int i = 0; i < NUM_CH; i++) begin
         clr_pend[i] = ~ctl_r[i][BIT_ENABLE];
      end
      case (st_r)
         ST_IDLE: begin
            for (int i = NUM_CH - 1; i >= 0; i--) begin
               if (chan_req[i]) begin
                  start    = 1'b1;
                  start_ch = 2'(i);
               end
            end
         end
         ST_READ: begin
            if (rs == RS_EXT_M2D) begin
               finish = 1'b1;
            end else begin
               st_nxt   = ST_WRITE;
               val_nxt  = 1'b1;
               wr_nxt   = 1'b1;
               addr_nxt = tgt_r[gnt_r];
            end
         end
         ST_WRITE: finish = 1'b1;
         default: st_nxt = ST_IDLE;
      endcase
      if (finish) begin
         step_org[gnt_r] = (rs != RS_EXT_D2M);
         step_tgt[gnt_r] = (rs != RS_EXT_M2D);
         st_nxt = ST_IDLE;
         // Burst keeps the channel while its request stands: the pin level, or the edge until disable.
         if (c[BIT_HOLD] && chan_req[gnt_r]) begin
            start    = 1'b1;
            start_ch = gnt_r;
         end
      end
      if (start) begin
         c       = ctl_r[start_ch];
         rs      = rs_of(c);
         gnt_nxt = start_ch;
         acc_nxt[start_ch] = 1'b1;
         // A cycle-steal edge request is used up by one transfer.
         clr_pend[start_ch] = ~c[BIT_HOLD] | clr_pend[start_ch];
         size_nxt = c[TS_LSB +: 3];
         val_nxt  = 1'b1;
         // A burst re-take in the finishing cycle must use the pointer that is stepped at this same edge.
         if (rs == RS_EXT_D2M) begin
            st_nxt   = ST_WRITE;
            wr_nxt   = 1'b1;
            addr_nxt = step_tgt[start_ch] ? step_ptr(tgt_r[start_ch], c[DM_LSB +: 2], c[TS_LSB +: 3])
                                          : tgt_r[start_ch];
         end else begin
            st_nxt   = ST_READ;
            addr_nxt = step_org[start_ch] ? step_ptr(org_r[start_ch], c[SM_LSB +: 2], c[TS_LSB +: 3])
                                          : org_r[start_ch];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r   <= ST_IDLE;
         gnt_r  <= 2'd0;
         acc_r  <= 4'h0;
         val_r  <= 1'b0;
         wr_r   <= 1'b0;
         addr_r <= PTR_RESET;
         size_r <= TS_QUAD;
      end else begin
         st_r   <= st_nxt;
         gnt_r  <= gnt_nxt;
         acc_r  <= acc_nxt;
         val_r  <= val_nxt;
         wr_r   <= wr_nxt;
         addr_r <= addr_nxt;
         size_r <= size_nxt;
      end
   end

   // Handshake outputs with per-channel polarity.
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         logic act, pol_rl, pol_al, sgl;
         pol_rl = (!ddt_r && i < 2) ? ctl_r[i][BIT_RL] : 1'b0;
         pol_al = (!ddt_r && i < 2) ? ctl_r[i][BIT_AL] : 1'b0;
         sgl    = is_ext(rs_of(ctl_r[i])) && rs_of(ctl_r[i]) != RS_EXT_DUAL;
         act    = (gnt_r == 2'(i)) && (sgl ? (st_r != ST_IDLE) :
                  (st_r == (am_eff(i, ddt_r, ctl_r[i]) ? ST_WRITE : ST_READ)));
         request_accepted_out[i] = acc_r[i] ^ pol_rl;
         transfer_ack_out[i]     = act ^ pol_al;
      end
   end

   assign xfer_valid_out = val_r;
   assign xfer_write_out = wr_r;
   assign xfer_chan_out  = gnt_r;
   assign xfer_size_out  = size_r;
   assign xfer_addr_out  = addr_r;

   // Register file: a software write to a pointer overrides a step in the same cycle.
   always_comb begin
      logic wr;
      logic [7:0] a;
      wr       = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
      a        = wb_adr_i;
      ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
      ddt_nxt  = ddt_r;
      dat_nxt  = 32'h0000_0000;
      for (int i = 0; i < NUM_CH; i++) begin
         logic [31:0] m;
         m = (i < 2) ? CTL_MASK_LOW : CTL_MASK_HIGH;
         ctl_nxt[i] = ctl_r[i];
         org_nxt[i] = step_org[i] ? step_ptr(org_r[i], ctl_r[i][SM_LSB +: 2], ctl_r[i][TS_LSB +: 3]) : org_r[i];
         tgt_nxt[i] = step_tgt[i] ? step_ptr(tgt_r[i], ctl_r[i][DM_LSB +: 2], ctl_r[i][TS_LSB +: 3]) : tgt_r[i];
         if (a == OFS_CTL_BASE + 8'(4 * i)) begin
            dat_nxt = ctl_r[i];
            if (wr) begin
               ctl_nxt[i] = merge(ctl_r[i], wb_dat_i, wb_sel_i) & m;
            end
         end
         if (a == OFS_PTR_BASE + 8'(8 * i)) begin
            dat_nxt = org_r[i];
            if (wr) begin
               org_nxt[i] = merge(org_r[i], wb_dat_i, wb_sel_i);
            end
         end
         if (a == OFS_PTR_BASE + 8'(8 * i + 4)) begin
            dat_nxt = tgt_r[i];
            if (wr) begin
               tgt_nxt[i] = merge(tgt_r[i], wb_dat_i, wb_sel_i);
            end
         end
      end
      if (a == OFS_OPER) begin
         dat_nxt[BIT_ON_DEMAND] = ddt_r;
         if (wr && wb_sel_i[1]) begin
            ddt_nxt = wb_dat_i[BIT_ON_DEMAND];
         end
      end
      if (a == OFS_STATUS) begin
         dat_nxt = {24'h00_0000, st_r, gnt_r, chan_req};
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ddt_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         for (int i = 0; i < NUM_CH; i++) begin
            ctl_r[i] <= CTL_RESET;
            org_r[i] <= PTR_RESET;
            tgt_r[i] <= PTR_RESET;
         end
      end else begin
         ddt_r <= ddt_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         for (int i = 0; i < NUM_CH; i++) begin
            ctl_r[i] <= ctl_nxt[i];
            org_r[i] <= org_nxt[i];
            tgt_r[i] <= tgt_nxt[i];
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   chk_reserved_read_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      (wb_ack_o && wb_adr_i[7:4] == 4'h0) |-> wb_dat_o[23:20] == 4'h0)
      else $error("reserved control bits read nonzero");
   chk_level_request_seen: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ctl_r[0][BIT_ENABLE] && !ctl_r[0][BIT_DS] && rs_of(ctl_r[0]) == RS_EXT_DUAL && !pin_s2_r[0])
      |-> chan_req[0])
      else $error("low level on request pin not taken");
   chk_ondemand_accept_high: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ddt_r && !acc_r[0]) |-> !request_accepted_out[0])
      else $error("accept output not active high in on-demand mode");
   chk_ack_read_phase: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!ddt_r && st_r == ST_READ && gnt_r == 2'd0 && rs_of(ctl_r[0]) == RS_AUTO_MM && !ctl_r[0][BIT_AM])
      |-> transfer_ack_out[0] != ctl_r[0][BIT_AL])
      else $error("ack missing in dual address read phase");
   chk_ack_idle_level: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!ddt_r && st_r == ST_IDLE) |-> transfer_ack_out[1] == ctl_r[1][BIT_AL])
      else $error("idle ack level wrong");
   chk_target_byte_inc: assert property (@(posedge core_clk) disable iff (sys_rst)
      (step_tgt[0] && ctl_r[0][DM_LSB +: 2] == PSTEP_INC && ctl_r[0][TS_LSB +: 3] == TS_BYTE && !wb_stb_i)
      |=> tgt_r[0] == $past(tgt_r[0]) + 32'h0000_0001)
      else $error("byte increment of target pointer wrong");
   chk_origin_block_dec: assert property (@(posedge core_clk) disable iff (sys_rst)
      (step_org[1] && ctl_r[1][SM_LSB +: 2] == PSTEP_DEC && ctl_r[1][TS_LSB +: 3] == TS_BLOCK && !wb_stb_i)
      |=> org_r[1] == $past(org_r[1]) - 32'h0000_0020)
      else $error("block decrement of origin pointer wrong");
   chk_no_ext_high_ch: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!ddt_r && is_ext(rs_of(ctl_r[2]))) |-> !chan_req[2])
      else $error("channel 2 took external request in normal mode");
   chk_auto_starts: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_r == ST_IDLE && chan_req != 4'h0) |=> (st_r != ST_IDLE && xfer_valid_out))
      else $error("requested channel did not start");

endmodule // dmacr_channels
`default_nettype wire

/* rtl/dmacr_req_detect.sv */
// One channel's request detector: low level or falling edge of the synchronised request pin.
// Assumes the pin input has already passed two flip-flops on core_clk.
`timescale 1ns/1ps
`default_nettype none
module dmacr_req_detect
   import dmacr_pkg::*;
(
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Request path.
   input  wire logic pin_sync_n,
   input  wire logic edge_mode,
   input  wire logic clear_pend,
   output logic      req
);
   logic prev_r;
   logic prev_nxt;
   logic pend_r;
   logic pend_nxt;

   always_comb begin
      prev_nxt = pin_sync_n;
      // A falling edge in the clearing cycle is kept.
      pend_nxt = (pend_r & ~clear_pend) | (prev_r & ~pin_sync_n);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prev_r <= 1'b1;
         pend_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         pend_r <= pend_nxt;
      end
   end

   assign req = edge_mode ? pend_r : ~pin_sync_n;

   chk_edge_pend_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      (prev_r && !pin_sync_n) |=> pend_r)
      else $error("falling edge did not set the pending request");

endmodule // dmacr_req_detect
`default_nettype wire

/* verification/dmacr_periph_model.sv */
// Model of the external device that drives the four active-low request pins.
// Assumes the bench says per channel, just after an edge, whether the device wants service.
`timescale 1ns/1ps
`default_nettype none
module dmacr_periph_model (
   // Clock.
   input  wire logic       core_clk,
   // Service wishes of the device.
   input  wire logic [3:0] want_service,
   // Request pins.
   output logic [3:0]      ext_xfer_request_pin_n
);
   logic [3:0] want_r;
   initial want_r = 4'h0;
   // The device answers a wish one cycle late, as a real part would.
   always @(posedge core_clk) begin
      want_r <= want_service;
   end
   // A released pin returns to its pulled-up idle level.
   assign ext_xfer_request_pin_n = ~want_r;
endmodule // dmacr_periph_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the four-channel request and pointer block.
// Assumes the peripheral model on the request pins and a Wishbone master in this module.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dmacr_pkg::*;
;
   localparam logic [31:0] STP [5] = '{32'h0000_0008, 32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0020};
   logic        core_clk  = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        wb_cyc_i  = 1'b0;
   logic        wb_stb_i  = 1'b0;
   logic        wb_we_i   = 1'b0;
   logic [7:0]  wb_adr_i  = 8'h00;
   logic [31:0] wb_dat_i  = 32'h0000_0000;
   logic [3:0]  serial_req = 4'h0;
   logic        tmr_req   = 1'b0;
   logic [3:0]  hold_req  = 4'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [3:0]  pin_n;
   logic [3:0]  acc_out;
   logic [3:0]  ack_out;
   logic        xv;
   logic        xw;
   logic [1:0]  xc;
   logic [2:0]  xs;
   logic [31:0] xa;
   logic [45:0] ph_q [$];
   logic [3:0]  ph_acc;
   logic [3:0]  ph_ack;
   logic        ph_w;
   logic [2:0]  ph_s;
   logic [1:0]  ph_c;
   logic [31:0] ph_a;
   int          fail_count = 0;
   int          n_checks   = 0;

   always #50 core_clk = ~core_clk;

   dmacr_channels u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_xfer_request_pin_n(pin_n), .serial_req(serial_req),
      .timer_capture_req(tmr_req), .request_accepted_out(acc_out), .transfer_ack_out(ack_out),
      .xfer_valid_out(xv), .xfer_write_out(xw), .xfer_chan_out(xc), .xfer_size_out(xs), .xfer_addr_out(xa));
   dmacr_periph_model u_dev (.core_clk(core_clk), .want_service(hold_req), .ext_xfer_request_pin_n(pin_n));

   // Every transfer phase is queued, so no phase is lost while a task is busy on the bus.
   always @(posedge core_clk) begin
      if (xv === 1'b1) begin
         ph_q.push_back({acc_out, ack_out, xw, xs, xc, xa});
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout();
      chk("timeout", 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000);
      final_report();
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) timeout();
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(what, q, exp);
   endtask

   task automatic phase();
      int n;
      n = 0;
      while (ph_q.size() == 0 && n < 60) begin
         @(posedge core_clk);
         n++;
      end
      if (ph_q.size() == 0) timeout();
      {ph_acc, ph_ack, ph_w, ph_s, ph_c, ph_a} = ph_q.pop_front();
   endtask

   task automatic watch(input int n, output int c);
      repeat (n) @(posedge core_clk);
      c = ph_q.size();
   endtask

   task automatic stop(input logic [7:0] a);
      wr(a, 32'h0000_0000);
      repeat (8) @(posedge core_clk);
      ph_q.delete();
   endtask

   function automatic logic [31:0] cw(input logic ds, rl, am, al, input logic [1:0] dm, sm,
                                      input logic [3:0] rs, mode);
      return {12'h000, ds, rl, am, al, dm, sm, rs, mode, 4'h1};
   endfunction

   task automatic t_regs();
      rd("ctl1 reset", 8'h04, CTL_RESET);
      rd("ptr reset", 8'h20, PTR_RESET);
      wr(8'h00, 32'hFFFF_5AC4);
      wr(8'h08, 32'hFFFF_5AC4);
      rd("ctl0", 8'h00, 32'hFF0F_5AC4);
      rd("ctl2", 8'h08, 32'hFF0A_5AC4);
      rd("unmapped", 8'hF0, 32'h0000_0000);
      wr(8'h00, 32'h0000_0000);
      wr(8'h08, 32'h0000_0000);
      $display("test regs done");
   endtask

   task automatic t_auto();
      logic rl;
      logic am;
      logic al;
      for (int i = 0; i < 5; i++) begin
         {rl, am, al} = 3'(i);
         wr(8'h20, 32'h0000_1000);
         wr(8'h24, 32'h0000_2000);
         wr(8'h00, cw(1'b0, rl, am, al, 2'h1, 2'h2, RS_AUTO_MM, {i[0], 3'(i)}));
         phase();
         chk("auto rd", {ph_w, ph_s, ph_acc[0], ph_ack[0], ph_a}, {1'b0, 3'(i), ~rl, ~am ^ al, 32'h0000_1000});
         phase();
         chk("auto wr", {ph_w, ph_acc[0], ph_ack[0], ph_a}, {1'b1, rl, am ^ al, 32'h0000_2000});
         phase();
         chk("origin step", {ph_w, ph_a}, {1'b0, 32'h0000_1000 - STP[i]});
         phase();
         chk("target step", {ph_w, ph_a}, {1'b1, 32'h0000_2000 + STP[i]});
         stop(8'h00);
      end
      $display("test auto done");
   endtask

   task automatic t_ext();
      int c;
      wr(8'h20, 32'h0000_0100);
      wr(8'h24, 32'h0000_0200);
      wr(8'h00, cw(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, RS_EXT_DUAL, {1'b0, TS_LONG}));
      watch(10, c);
      chk("ext idle", c, 0);
      hold_req <= 4'h1;
      phase();
      chk("ext rd", {ph_w, ph_c, ph_a}, {1'b0, 2'h0, 32'h0000_0100});
      phase();
      chk("ext wr", {ph_w, ph_c, ph_a}, {1'b1, 2'h0, 32'h0000_0200});
      hold_req <= 4'h0;
      stop(8'h00);
      foreach (STP[k]) begin
         wr(8'h00, cw(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, k[0] ? 4'h7 : 4'h1, {1'b0, TS_LONG}));
         hold_req <= 4'h1;
         watch(12, c);
         chk("prohibited code", c, 0);
         hold_req <= 4'h0;
         stop(8'h00);
      end
      wr(8'h08, cw(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, RS_EXT_DUAL, {1'b0, TS_LONG}));
      hold_req <= 4'h4;
      watch(12, c);
      chk("ch2 normal", c, 0);
      wr(8'h10, 32'h0000_8000);
      phase();
      chk("ch2 on demand", ph_c, 2'h2);
      hold_req <= 4'h0;
      wr(8'h10, 32'h0000_0000);
      stop(8'h08);
      for (int m = 0; m < 4; m++) begin
         wr(8'h04, cw(m[0], 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, RS_EXT_DUAL, {m[1], TS_LONG}));
         hold_req <= 4'h2;
         watch(30, c);
         chk("sampling", c > 2, m != 1);
         hold_req <= 4'h0;
         repeat (10) @(posedge core_clk);
         ph_q.delete();
         watch(20, c);
         chk("burst after release", c > 0, m == 3);
         stop(8'h04);
      end
      $display("test ext done");
   endtask

   task automatic t_single();
      for (int k = 0; k < 2; k++) begin
         wr(8'h20, 32'h0000_0100);
         wr(8'h24, 32'h0000_0200);
         wr(8'h00, cw(1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 2'h1, k[0] ? RS_EXT_D2M : RS_EXT_M2D, {1'b0, TS_LONG}));
         hold_req <= 4'h1;
         phase();
         chk("single 1", {ph_w, ph_ack[0], ph_a}, {k[0], 1'b1, k[0] ? 32'h0000_0200 : 32'h0000_0100});
         phase();
         chk("single 2", {ph_w, ph_ack[0], ph_a}, {k[0], 1'b1, k[0] ? 32'h0000_0204 : 32'h0000_0104});
         hold_req <= 4'h0;
         stop(8'h00);
         rd("ignored ptr", k[0] ? 8'h20 : 8'h24, k[0] ? 32'h0000_0100 : 32'h0000_0200);
      end
      $display("test single done");
   endtask

   task automatic t_periph();
      int c;
      for (int j = 0; j < 7; j++) begin
         wr(8'h04, cw(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2, 4'(8 + j), {1'b0, TS_BLOCK}));
         serial_req <= (j < 4) ? ~(4'h1 << j) : 4'hF;
         tmr_req <= (j < 4);
         watch(10, c);
         chk("wrong source", c, 0);
         serial_req <= (j < 4) ? 4'hF : 4'h0;
         tmr_req <= 1'b1;
         phase();
         chk("source taken", ph_c, 2'h1);
         serial_req <= 4'h0;
         tmr_req <= 1'b0;
         stop(8'h04);
      end
      $display("test periph done");
   endtask

   initial begin
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_auto();
      t_ext();
      t_single();
      t_periph();
      final_report();
   end
endmodule // tb_top
`default_nettype wire
